// *** design/nco_pkg.sv ***
// Package of register map, field layout and encodings for the oscillator
package nco_pkg;
  // Register byte addresses on the bus
  localparam logic [5:0] ADDR_CONTROL   = 6'h00;
  localparam logic [5:0] ADDR_CLOCK_CTL = 6'h04;
  localparam logic [5:0] ADDR_ACC_LOW   = 6'h08;
  localparam logic [5:0] ADDR_ACC_HIGH  = 6'h0c;
  localparam logic [5:0] ADDR_ACC_UPPER = 6'h10;
  localparam logic [5:0] ADDR_INC_LOW   = 6'h14;
  localparam logic [5:0] ADDR_INC_HIGH  = 6'h18;
  localparam logic [5:0] ADDR_INC_UPPER = 6'h1c;
  localparam logic [5:0] ADDR_IRQ       = 6'h20;
  // Control register bits
  localparam int CTL_ON_BIT  = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_INV_BIT = 4;
  localparam int CTL_PFM_BIT = 0;
  // Clock control fields
  localparam int CLK_PWS_LSB = 5;
  localparam int CLK_CKS_LSB = 0;
  // Interrupt register bits
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_IE_BIT   = 1;
  localparam int IRQ_PE_BIT   = 2;
  localparam int IRQ_GIE_BIT  = 3;
  // Widths and reset values
  localparam int         ACC_W       = 20;
  localparam int         UPPER_W     = 4;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] WIDTH_ONE   = 8'h01;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Clock source select encodings
  localparam logic [2:0] CKS_SYSTEM = 3'h0;
  localparam logic [2:0] CKS_HF_OSC = 3'h1;
  localparam logic [2:0] CKS_LC1    = 3'h2;
  localparam logic [2:0] CKS_LC4    = 3'h5;
  // Register index for address decode
  typedef enum logic [3:0] {
    REG_CONTROL, REG_CLOCK_CTL, REG_ACC_LOW, REG_ACC_HIGH, REG_ACC_UPPER,
    REG_INC_LOW, REG_INC_HIGH, REG_INC_UPPER, REG_IRQ, REG_NONE
  } reg_sel_t;
  // Shadow load sequencer, Gray along the load path
  typedef enum logic [1:0] {
    LOAD_IDLE   = 2'b00,
    LOAD_ARMED  = 2'b01,
    LOAD_SECOND = 2'b11
  } load_state_t;
endpackage

// *** design/numerically_controlled_oscillator.sv ***
// Phase-accumulator oscillator with AXI4-Lite register slave
// Operation
// - 20-bit accumulator, readable and writable through low, high, upper bytes.
// - Adder sums accumulator and shadow increment on each selected clock rising edge.
// - Adder carry out is the raw overflow event.
// - Six input clock sources chosen by the clock source select field.
// - Select codes: 0 system, 1 hf osc, 2..5 logic cells, 6..7 reserved.
// - 20-bit increment held in low, high, upper byte registers.
// - Enabled: low byte write loads shadows on second input clock edge after.
// - Disabled: shadows follow increment writes immediately.
// - Shadows are hidden; increment reads return written values.
// - Fixed duty mode toggles output on every overflow.
// - Pulse mode select bit: 0 fixed duty, 1 pulse frequency.
// - Pulse mode: output goes active at the overflow edge for chosen periods.
// - Pulse width field in clock control sets active periods.
// - Width code n gives 2 to the n input clock periods.
// - Final stage applies polarity and feeds peripherals.
// - Invert bit 1 inverts output, 0 passes unchanged.
// - Polarity change with interrupts enabled raises an interrupt.
// - Every overflow sets the overflow interrupt flag.
// - Interrupt request needs module on and three enables plus flag.
// - Module on bit enables the oscillator.
// - Reset clears every register to zero.
// - Runs from its own selected clock, independent of system sleep.
// - Keeps hf oscillator running in sleep when enabled and selected.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
module numerically_controlled_oscillator (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        internal_hf_oscillator,
  input  wire logic        logic_cell_1_output,
  input  wire logic        logic_cell_2_output,
  input  wire logic        logic_cell_3_output,
  input  wire logic        logic_cell_4_output,
  output logic             osc_out,
  output logic             accum_carry_event,
  output logic             irq,
  output logic             hf_osc_keep_on
);
  localparam int AW = nco_pkg::ACC_W;

  // Address decode shared by read and write paths
  function automatic nco_pkg::reg_sel_t decode(input logic [5:0] a);
    case (a)
      nco_pkg::ADDR_CONTROL:   decode = nco_pkg::REG_CONTROL;
      nco_pkg::ADDR_CLOCK_CTL: decode = nco_pkg::REG_CLOCK_CTL;
      nco_pkg::ADDR_ACC_LOW:   decode = nco_pkg::REG_ACC_LOW;
      nco_pkg::ADDR_ACC_HIGH:  decode = nco_pkg::REG_ACC_HIGH;
      nco_pkg::ADDR_ACC_UPPER: decode = nco_pkg::REG_ACC_UPPER;
      nco_pkg::ADDR_INC_LOW:   decode = nco_pkg::REG_INC_LOW;
      nco_pkg::ADDR_INC_HIGH:  decode = nco_pkg::REG_INC_HIGH;
      nco_pkg::ADDR_INC_UPPER: decode = nco_pkg::REG_INC_UPPER;
      nco_pkg::ADDR_IRQ:       decode = nco_pkg::REG_IRQ;
      default:                 decode = nco_pkg::REG_NONE;
    endcase
  endfunction

  logic                 aw_got_ff, w_got_ff;
  logic [5:0]           awaddr_ff;
  logic [7:0]           wbyte_ff;
  logic                 wlane_ff;
  logic                 bvalid_ff, rvalid_ff;
  logic [1:0]           bresp_ff, rresp_ff;
  logic [31:0]          rdata_ff;
  logic                 do_write;
  nco_pkg::reg_sel_t    wsel;
  logic [7:0]           ctl_ff, clk_ff;
  logic [AW-1:0]        acc_ff, inc_ff, shadow_ff;
  logic [AW-1:0]        nxt_inc, nxt_acc;
  logic                 flag_ff, ie_ff, pe_ff, gie_ff;
  logic [4:0]           src_s1_ff, src_s2_ff, src_s3_ff;
  logic [4:0]           src_rise;
  logic                 tick;
  logic                 osc_on, pfm, inv;
  logic [2:0]           cks, pws;
  logic [AW:0]          sum;
  logic                 ovf;
  nco_pkg::load_state_t load_ff;
  logic                 toggle_ff, pulse_ff;
  logic [7:0]           pcnt_ff, width;
  logic                 raw_level;
  logic                 out_ff, inv_prev_ff, irq_ff, carry_ff;
  logic                 irqs_enabled, pol_event;

  assign osc_on = ctl_ff[nco_pkg::CTL_ON_BIT];
  assign pfm    = ctl_ff[nco_pkg::CTL_PFM_BIT];
  assign inv    = ctl_ff[nco_pkg::CTL_INV_BIT];
  assign cks    = clk_ff[nco_pkg::CLK_CKS_LSB +: 3];
  assign pws    = clk_ff[nco_pkg::CLK_PWS_LSB +: 3];

  // Bus handshakes: one write and one read in flight
  assign awready  = !aw_got_ff && !bvalid_ff;
  assign wready   = !w_got_ff && !bvalid_ff;
  assign arready  = !rvalid_ff;
  assign do_write = aw_got_ff && w_got_ff;
  assign wsel     = do_write && wlane_ff ? decode(awaddr_ff) : nco_pkg::REG_NONE;
  assign bvalid   = bvalid_ff;
  assign bresp    = bresp_ff;
  assign rvalid   = rvalid_ff;
  assign rresp    = rresp_ff;
  assign rdata    = rdata_ff;

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 6'h00;
      wbyte_ff  <= nco_pkg::REG_RESET;
      wlane_ff  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end else if (do_write) begin
        aw_got_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got_ff <= 1'b1;
        wbyte_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];
      end else if (do_write) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= nco_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= decode(awaddr_ff) == nco_pkg::REG_NONE ? nco_pkg::RESP_SLVERR : nco_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read path, live state in status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= nco_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= nco_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
      case (decode(araddr))
        nco_pkg::REG_CONTROL: begin
          rdata_ff[7:0]                 <= ctl_ff;
          rdata_ff[nco_pkg::CTL_OUT_BIT] <= out_ff;
        end
        nco_pkg::REG_CLOCK_CTL: rdata_ff[7:0] <= clk_ff;
        nco_pkg::REG_ACC_LOW:   rdata_ff[7:0] <= acc_ff[7:0];
        nco_pkg::REG_ACC_HIGH:  rdata_ff[7:0] <= acc_ff[15:8];
        nco_pkg::REG_ACC_UPPER: rdata_ff[3:0] <= acc_ff[19:16];
        nco_pkg::REG_INC_LOW:   rdata_ff[7:0] <= inc_ff[7:0];
        nco_pkg::REG_INC_HIGH:  rdata_ff[7:0] <= inc_ff[15:8];
        nco_pkg::REG_INC_UPPER: rdata_ff[3:0] <= inc_ff[19:16];
        nco_pkg::REG_IRQ:       rdata_ff[3:0] <= {gie_ff, pe_ff, ie_ff, flag_ff};
        default:                rresp_ff      <= nco_pkg::RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Control and clock control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= nco_pkg::REG_RESET;
      clk_ff <= nco_pkg::REG_RESET;
    end else begin
      if (wsel == nco_pkg::REG_CONTROL) begin
        ctl_ff <= wbyte_ff & 8'h91;
      end
      if (wsel == nco_pkg::REG_CLOCK_CTL) begin
        clk_ff <= wbyte_ff & 8'he7;
      end
    end
  end

  // Increment registers as written by software
  always_comb begin
    nxt_inc = inc_ff;
    case (wsel)
      nco_pkg::REG_INC_LOW:   nxt_inc[7:0]   = wbyte_ff;
      nco_pkg::REG_INC_HIGH:  nxt_inc[15:8]  = wbyte_ff;
      nco_pkg::REG_INC_UPPER: nxt_inc[19:16] = wbyte_ff[nco_pkg::UPPER_W-1:0];
      default:                nxt_inc        = inc_ff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) inc_ff <= '0;
    else          inc_ff <= nxt_inc;
  end

  // Two-flop synchronisers and edge detect on external clock sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_s1_ff <= 5'h00;
      src_s2_ff <= 5'h00;
      src_s3_ff <= 5'h00;
    end else begin
      src_s1_ff <= {logic_cell_4_output, logic_cell_3_output, logic_cell_2_output,
                    logic_cell_1_output, internal_hf_oscillator};
      src_s2_ff <= src_s1_ff;
      src_s3_ff <= src_s2_ff;
    end
  end
  assign src_rise = src_s2_ff & ~src_s3_ff;

  // Input clock select; system source ticks every cycle
  always_comb begin
    tick = 1'b0;
    if (cks == nco_pkg::CKS_SYSTEM) tick = 1'b1;
    else if (cks == nco_pkg::CKS_HF_OSC) tick = src_rise[0];
    else if (cks >= nco_pkg::CKS_LC1 && cks <= nco_pkg::CKS_LC4) tick = src_rise[cks - nco_pkg::CKS_LC1 + 3'h1];
  end

  // Adder and overflow carry
  assign sum = {1'b0, acc_ff} + {1'b0, shadow_ff};
  assign ovf = tick && osc_on && sum[AW];

  always_comb begin
    nxt_acc = acc_ff;
    if (tick && osc_on) nxt_acc = sum[AW-1:0];
    case (wsel)
      nco_pkg::REG_ACC_LOW:   nxt_acc[7:0]   = wbyte_ff;
      nco_pkg::REG_ACC_HIGH:  nxt_acc[15:8]  = wbyte_ff;
      nco_pkg::REG_ACC_UPPER: nxt_acc[19:16] = wbyte_ff[nco_pkg::UPPER_W-1:0];
      default:                nxt_acc        = nxt_acc;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) acc_ff <= '0;
    else          acc_ff <= nxt_acc;
  end

  // Shadow load sequencer: two input clock edges after low byte write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_ff   <= nco_pkg::LOAD_IDLE;
      shadow_ff <= '0;
    end else if (!osc_on) begin
      load_ff   <= nco_pkg::LOAD_IDLE;
      shadow_ff <= nxt_inc;
    end else if (wsel == nco_pkg::REG_INC_LOW) begin
      load_ff <= nco_pkg::LOAD_ARMED;
    end else begin
      case (load_ff)
        nco_pkg::LOAD_IDLE:   load_ff <= nco_pkg::LOAD_IDLE;
        nco_pkg::LOAD_ARMED:  if (tick) load_ff <= nco_pkg::LOAD_SECOND;
        nco_pkg::LOAD_SECOND: if (tick) begin
          load_ff   <= nco_pkg::LOAD_IDLE;
          shadow_ff <= inc_ff;
        end
        default:              load_ff <= nco_pkg::LOAD_IDLE;
      endcase
    end
  end

  // Fixed duty toggle and pulse stretcher
  assign width = nco_pkg::WIDTH_ONE << pws;
  always_ff @(posedge aclk) begin
    if (!aresetn || !osc_on) begin
      toggle_ff <= 1'b0;
      pulse_ff  <= 1'b0;
      pcnt_ff   <= 8'h00;
    end else begin
      if (ovf) toggle_ff <= !toggle_ff;
      if (ovf) begin
        pulse_ff <= 1'b1;
        pcnt_ff  <= width;
      end else if (tick && pulse_ff) begin
        pulse_ff <= pcnt_ff != nco_pkg::WIDTH_ONE;
        pcnt_ff  <= pcnt_ff - nco_pkg::WIDTH_ONE;
      end
    end
  end

  // Mode select then polarity
  assign raw_level = osc_on && (pfm ? pulse_ff : toggle_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) out_ff <= 1'b0;
    else          out_ff <= raw_level ^ inv;
  end

  // Interrupt flag, enables and request
  assign irqs_enabled = ie_ff && pe_ff && gie_ff;
  assign pol_event    = (inv != inv_prev_ff) && irqs_enabled;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff     <= 1'b0;
      ie_ff       <= 1'b0;
      pe_ff       <= 1'b0;
      gie_ff      <= 1'b0;
      inv_prev_ff <= 1'b0;
      irq_ff      <= 1'b0;
      carry_ff    <= 1'b0;
    end else begin
      inv_prev_ff <= inv;
      carry_ff    <= ovf;
      if (wsel == nco_pkg::REG_IRQ) begin
        ie_ff  <= wbyte_ff[nco_pkg::IRQ_IE_BIT];
        pe_ff  <= wbyte_ff[nco_pkg::IRQ_PE_BIT];
        gie_ff <= wbyte_ff[nco_pkg::IRQ_GIE_BIT];
      end
      // Set wins over software clear
      if (ovf || pol_event) flag_ff <= 1'b1;
      else if (wsel == nco_pkg::REG_IRQ && !wbyte_ff[nco_pkg::IRQ_FLAG_BIT]) flag_ff <= 1'b0;
      irq_ff <= osc_on && irqs_enabled && flag_ff;
    end
  end

  assign osc_out           = out_ff;
  assign accum_carry_event = carry_ff;
  assign irq               = irq_ff;
  assign hf_osc_keep_on    = osc_on && cks == nco_pkg::CKS_HF_OSC;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_overflow_sets_flag: assert property (ovf |=> flag_ff) else $error("overflow did not set flag");
  a_irq_gating: assert property (irq_ff == $past(osc_on && irqs_enabled && flag_ff))
    else $error("irq gating wrong");
  a_acc_add: assert property (tick && osc_on && wsel == nco_pkg::REG_NONE |=> acc_ff == $past(sum[AW-1:0]))
    else $error("accumulator sum wrong");
  a_acc_hold_off: assert property (!osc_on && wsel == nco_pkg::REG_NONE |=> $stable(acc_ff))
    else $error("accumulator moved while off");
  a_shadow_second: assert property (osc_on && load_ff == nco_pkg::LOAD_SECOND && tick
    && wsel == nco_pkg::REG_NONE |=> shadow_ff == $past(inc_ff)) else $error("shadow not loaded");
  a_shadow_two_edges: assert property (osc_on && wsel == nco_pkg::REG_INC_LOW ##1 osc_on && !tick
    |=> $stable(shadow_ff)) else $error("shadow loaded early");
  a_shadow_off: assert property (!osc_on |=> shadow_ff == $past(nxt_inc)) else $error("shadow lag off");
  a_fdc_toggle: assert property (ovf |=> toggle_ff != $past(toggle_ff)) else $error("no toggle");
  a_pulse_start: assert property (ovf |=> pulse_ff && pcnt_ff == $past(width)) else $error("pulse start");
  a_polarity: assert property (out_ff == $past(raw_level ^ inv)) else $error("polarity wrong");
  a_off_inactive: assert property (!osc_on |=> !toggle_ff && !pulse_ff && out_ff == $past(inv))
    else $error("active while off");

  c_fdc_overflow: cover property (ovf && !pfm);
  c_pulse_end:    cover property (pulse_ff && pfm ##1 !pulse_ff);
  c_pol_irq:      cover property (pol_event ##2 irq_ff);
  c_shadow_load:  cover property (load_ff == nco_pkg::LOAD_SECOND && tick && osc_on);
endmodule // numerically_controlled_oscillator

// *** tb/nco_partner.sv ***
// Free-running clock sources that feed the oscillator's source selector
module nco_partner (
  output logic hf_clk,
  output logic lc1_clk,
  output logic lc2_clk,
  output logic lc3_clk,
  output logic lc4_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Periods of 6, 8, 10, 12 and 14 bus clocks, offset so no edge meets aclk
  initial begin
    hf_clk = 1'b0;
    #1.3;
    forever #24 hf_clk = ~hf_clk;
  end
  initial begin
    lc1_clk = 1'b0;
    #2.1;
    forever #32 lc1_clk = ~lc1_clk;
  end
  initial begin
    lc2_clk = 1'b0;
    #0.7;
    forever #40 lc2_clk = ~lc2_clk;
  end
  initial begin
    lc3_clk = 1'b0;
    #3.3;
    forever #48 lc3_clk = ~lc3_clk;
  end
  initial begin
    lc4_clk = 1'b0;
    #1.9;
    forever #56 lc4_clk = ~lc4_clk;
  end
endmodule // nco_partner

// *** tb/tb_numerically_controlled_oscillator.sv ***
// Self-checking bench for the phase-accumulator oscillator
module tb_numerically_controlled_oscillator;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [5:0]  awaddr  = 6'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [5:0]  araddr  = 6'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rdv;
  logic        hf_clk, lc1_clk, lc2_clk, lc3_clk, lc4_clk;
  logic        osc_out, accum_carry_event, irq, hf_osc_keep_on;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          highs, carries;

  numerically_controlled_oscillator uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .internal_hf_oscillator(hf_clk), .logic_cell_1_output(lc1_clk),
    .logic_cell_2_output(lc2_clk), .logic_cell_3_output(lc3_clk),
    .logic_cell_4_output(lc4_clk), .osc_out(osc_out), .accum_carry_event(accum_carry_event),
    .irq(irq), .hf_osc_keep_on(hf_osc_keep_on)
  );
  nco_partner partner (
    .hf_clk(hf_clk), .lc1_clk(lc1_clk), .lc2_clk(lc2_clk), .lc3_clk(lc3_clk), .lc4_clk(lc4_clk)
  );

  // Bus clock
  initial begin
    forever #4 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write: address and data offered together, held until each is taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Count active output cycles and carry pulses over a window
  task automatic sample(input int n);
    highs = 0;
    carries = 0;
    repeat (n) begin
      @(posedge aclk);
      if (osc_out === 1'b1) highs++;
      if (accum_carry_event === 1'b1) carries++;
    end
  endtask

  task automatic set_inc(input logic [19:0] v);
    wr(nco_pkg::ADDR_INC_UPPER, {4'h0, v[19:16]});
    wr(nco_pkg::ADDR_INC_HIGH, v[15:8]);
    wr(nco_pkg::ADDR_INC_LOW, v[7:0]);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 9; i++) begin
      rd(6'(i * 4));
      chk("reset value", 32'h0, rdv);
    end
    rd(6'h24);
    chk("unmapped read resp", 32'(nco_pkg::RESP_SLVERR), 32'(resp));
    wr(6'h28, 8'h55);
    chk("unmapped write resp", 32'(nco_pkg::RESP_SLVERR), 32'(resp));
    $display("test reset done");
  endtask

  // Accumulator and increment bytes, upper bytes hold four bits
  task automatic t_regs();
    logic [7:0] e;
    for (int i = 2; i < 8; i++) begin
      wr(6'(i * 4), 8'hf0 | 8'(i));
    end
    sample(40);
    chk("off output", 32'h0, 32'(osc_out));
    for (int i = 2; i < 8; i++) begin
      e = (i == 4 || i == 7) ? 8'(i) : (8'hf0 | 8'(i));
      rd(6'(i * 4));
      chk("byte readback", 32'(e), rdv);
    end
    $display("test regs done");
  endtask

  task automatic t_fixed();
    wr(nco_pkg::ADDR_IRQ, 8'h0e);
    set_inc(20'h40000);
    wr(nco_pkg::ADDR_CONTROL, 8'h80);
    sample(16);
    sample(64);
    chk("fixed carries", 32'd16, 32'(carries));
    chk("fixed highs", 32'd32, 32'(highs));
    chk("irq line", 32'h1, 32'(irq));
    rd(nco_pkg::ADDR_IRQ);
    chk("irq reg", 32'h0f, rdv);
    set_inc(20'h20000);
    sample(32);
    sample(64);
    chk("reloaded carries", 32'd8, 32'(carries));
    chk("reloaded highs", 32'd32, 32'(highs));
    $display("test fixed done");
  endtask

  task automatic t_flag();
    wr(nco_pkg::ADDR_CONTROL, 8'h00);
    sample(8);
    rd(nco_pkg::ADDR_IRQ);
    chk("flag kept", 32'h0f, rdv);
    chk("irq while off", 32'h0, 32'(irq));
    wr(nco_pkg::ADDR_IRQ, 8'h0e);
    rd(nco_pkg::ADDR_IRQ);
    chk("flag cleared", 32'h0e, rdv);
    wr(nco_pkg::ADDR_CONTROL, 8'h10);
    sample(4);
    rd(nco_pkg::ADDR_IRQ);
    chk("polarity flag", 32'h0f, rdv);
    chk("inverted idle", 32'h1, 32'(osc_out));
    rd(nco_pkg::ADDR_CONTROL);
    chk("out bit", 32'h30, rdv);
    wr(nco_pkg::ADDR_CONTROL, 8'h00);
    wr(nco_pkg::ADDR_IRQ, 8'h00);
    $display("test flag done");
  endtask

  // Overflow every 512 ticks; every width code stays below that
  task automatic t_pulse();
    set_inc(20'h00800);
    wr(nco_pkg::ADDR_CONTROL, 8'h81);
    for (int c = 0; c < 8; c++) begin
      wr(nco_pkg::ADDR_CLOCK_CTL, 8'(c << 5));
      sample(520);
      sample(512);
      chk("pulse highs", 32'(1 << c), 32'(highs));
      chk("pulse carries", 32'd1, 32'(carries));
    end
    wr(nco_pkg::ADDR_CONTROL, 8'h91);
    sample(20);
    sample(512);
    chk("inverted highs", 32'd384, 32'(highs));
    wr(nco_pkg::ADDR_CONTROL, 8'h00);
    $display("test pulse done");
  endtask

  // Each source code, with the partner's clock periods in bus cycles
  task automatic t_sources();
    int per [8] = '{1, 6, 8, 10, 12, 14, 0, 0};
    int e;
    set_inc(20'h80000);
    wr(nco_pkg::ADDR_CONTROL, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr(nco_pkg::ADDR_CLOCK_CTL, 8'(c));
      sample(24);
      sample(336);
      e = (per[c] == 0) ? 0 : 168 / per[c];
      chk("source carries", 32'(e), 32'((carries - e <= 1 && e - carries <= 1) ? e : carries));
      chk("hf keep on", 32'(c == 1), 32'(hf_osc_keep_on));
    end
    // Reload while running from the hf source: shadow waits for two source ticks
    wr(nco_pkg::ADDR_CLOCK_CTL, 8'h01);
    set_inc(20'h40000);
    sample(48);
    sample(336);
    chk("hf reload carries", 32'd14, 32'(carries));
    wr(nco_pkg::ADDR_CONTROL, 8'h00);
    sample(2);
    chk("hf keep off", 32'h0, 32'(hf_osc_keep_on));
    $display("test sources done");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_fixed();
    t_flag();
    t_pulse();
    t_sources();
    conclude();
  end
endmodule // tb_numerically_controlled_oscillator
